// >>> core/weigh_cmd_status.sv
`timescale 1ns/10ps
`default_nettype none

module weigh_cmd_status #(
    parameter int TickCycles = weigh_pkg::TICK_CYCLES
) (
    input  wire logic                                  clk,
    input  wire logic                                  rst,
    input  wire logic        [weigh_pkg::CMD_W-1:0]    cmdByte,
    output logic             [weigh_pkg::CMD_W-1:0]    statusByte,
    input  wire logic                                  sampleValid,
    input  wire logic signed [weigh_pkg::DATA_W-1:0]   sampleData,
    output logic                                       filterValid,
    output logic signed      [weigh_pkg::DATA_W-1:0]   filterData,
    input  wire logic        [weigh_pkg::DWELL_W-1:0]  steadyDwellTime,
    input  wire logic        [weigh_pkg::DATA_W-1:0]   steadyToleranceBand,
    input  wire logic        [weigh_pkg::DATA_W-1:0]   calibrationInterval,
    output logic                                       calMeasReq,
    output logic                                       calRefSel,
    input  wire logic                                  calRefValid,
    input  wire logic signed [weigh_pkg::DATA_W-1:0]   calRefData,
    output logic signed      [weigh_pkg::DATA_W-1:0]   calOffset,
    output logic signed      [weigh_pkg::DATA_W-1:0]   calGain,
    output logic signed      [weigh_pkg::DATA_W-1:0]   tareValue,
    output logic                                       adjStoreReq,
    output logic                                       adjDeleteReq,
    input  wire logic                                  adjDone,
    input  wire logic                                  adjFail,
    output logic                                       zeroPointPulse,
    output logic                                       refPointPulse
);
    import weigh_pkg::*;

    logic        [CMD_W-1:0]  cmdPrev_q;
    logic        [CMD_W-1:0]  cmdRise;
    logic                     tareHeld;
    logic                     adjHeld;
    logic                     zeroHeld;
    logic        [31:0]       tickCnt_q;
    logic                     tick_q;
    logic signed [DATA_W-1:0] lastSample_q;
    logic                     steady;
    logic                     tareChanged_q;
    logic                     adjBusy_q;
    logic                     adjChanged_q;
    logic                     adjError_q;
    logic                     zeroRef_q;
    cal_state_t               calState_q;
    logic        [31:0]       calTimer_q;
    logic signed [DATA_W-1:0] calLow_q;
    logic                     calStart;
    logic        [CMD_W-1:0]  statusD;

    always_ff @(posedge clk) begin
        if (rst) begin
            cmdPrev_q <= '0;
        end else begin
            cmdPrev_q <= cmdByte;
        end
    end

    always_comb begin
        cmdRise  = cmdByte & ~cmdPrev_q;
        tareHeld = cmdByte[CMD_TARE_SET] | cmdByte[CMD_TARE_CLEAR];
        adjHeld  = cmdByte[CMD_ADJ_STORE] | cmdByte[CMD_ADJ_DELETE];
        zeroHeld = cmdByte[CMD_ZERO_SET] | cmdByte[CMD_REF_SET];
    end

    // Millisecond time base shared by dwell and calibration interval.
    always_ff @(posedge clk) begin
        if (rst) begin
            tickCnt_q <= '0;
            tick_q    <= 1'b0;
        end else if (tickCnt_q >= 32'(TickCycles - 1)) begin
            tickCnt_q <= '0;
            tick_q    <= 1'b1;
        end else begin
            tickCnt_q <= tickCnt_q + 32'h0000_0001;
            tick_q    <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            filterValid  <= 1'b0;
            filterData   <= DATA_RESET;
            lastSample_q <= DATA_RESET;
        end else begin
            filterValid <= sampleValid && !cmdByte[CMD_HOLD];
            if (sampleValid && !cmdByte[CMD_HOLD]) begin
                filterData <= sampleData;
            end
            if (sampleValid) begin
                lastSample_q <= sampleData;
            end
        end
    end

    steady_watch u_steady (
        .clk           (clk),
        .rst           (rst),
        .tick          (tick_q),
        .sampleValid   (sampleValid),
        .sampleData    (sampleData),
        .dwellTime     (steadyDwellTime),
        .toleranceBand (steadyToleranceBand),
        .steady        (steady)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            tareValue <= TARE_CLEARED;
        end else if (cmdRise[CMD_TARE_CLEAR]) begin
            tareValue <= TARE_CLEARED;
        end else if (cmdRise[CMD_TARE_SET]) begin
            tareValue <= lastSample_q;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tareChanged_q <= 1'b0;
        end else if (cmdRise[CMD_TARE_SET] || cmdRise[CMD_TARE_CLEAR]) begin
            tareChanged_q <= 1'b1;
        end else if (!tareHeld) begin
            tareChanged_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            adjBusy_q    <= 1'b0;
            adjStoreReq  <= 1'b0;
            adjDeleteReq <= 1'b0;
        end else begin
            adjStoreReq  <= 1'b0;
            adjDeleteReq <= 1'b0;
            if (!adjBusy_q) begin
                if (cmdRise[CMD_ADJ_DELETE]) begin
                    adjDeleteReq <= 1'b1;
                    adjBusy_q    <= 1'b1;
                end else if (cmdRise[CMD_ADJ_STORE]) begin
                    adjStoreReq <= 1'b1;
                    adjBusy_q   <= 1'b1;
                end
            end else if (adjDone || adjFail) begin
                adjBusy_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            adjChanged_q <= 1'b0;
        end else if (adjBusy_q && (adjDone || adjFail)) begin
            adjChanged_q <= 1'b1;
        end else if (!adjHeld) begin
            adjChanged_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            adjError_q <= 1'b0;
        end else if (adjBusy_q && adjFail) begin
            adjError_q <= 1'b1;
        end else if (!adjHeld) begin
            adjError_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            zeroPointPulse <= 1'b0;
            refPointPulse  <= 1'b0;
        end else begin
            zeroPointPulse <= cmdRise[CMD_ZERO_SET];
            refPointPulse  <= cmdRise[CMD_REF_SET];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            zeroRef_q <= 1'b0;
        end else if (cmdRise[CMD_ZERO_SET] || cmdRise[CMD_REF_SET]) begin
            zeroRef_q <= 1'b1;
        end else if (!zeroHeld) begin
            zeroRef_q <= 1'b0;
        end
    end

    // An interval of zero leaves periodic self-calibration switched off.
    assign calStart = calState_q == CAL_IDLE && calibrationInterval != '0
                      && calTimer_q >= calibrationInterval - 32'h0000_0001;

    always_ff @(posedge clk) begin
        if (rst) begin
            calTimer_q <= '0;
        end else if (calState_q != CAL_IDLE || calStart) begin
            calTimer_q <= '0;
        end else if (tick_q) begin
            calTimer_q <= calTimer_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            calState_q <= CAL_IDLE;
            calMeasReq <= 1'b0;
            calRefSel  <= 1'b0;
            calLow_q   <= DATA_RESET;
            calOffset  <= DATA_RESET;
            calGain    <= DATA_RESET;
        end else begin
            calMeasReq <= 1'b0;
            case (calState_q)
                CAL_IDLE: begin
                    if (calStart) begin
                        calState_q <= CAL_REQ_LOW;
                    end
                end
                CAL_REQ_LOW: begin
                    calRefSel  <= 1'b0;
                    calMeasReq <= 1'b1;
                    calState_q <= CAL_WAIT_LOW;
                end
                CAL_WAIT_LOW: begin
                    if (calRefValid) begin
                        calLow_q   <= calRefData;
                        calState_q <= CAL_REQ_HIGH;
                    end
                end
                CAL_REQ_HIGH: begin
                    calRefSel  <= 1'b1;
                    calMeasReq <= 1'b1;
                    calState_q <= CAL_WAIT_HIGH;
                end
                CAL_WAIT_HIGH: begin
                    if (calRefValid) begin
                        calOffset  <= calLow_q;
                        calGain    <= calRefData - calLow_q;
                        calRefSel  <= 1'b0;
                        calState_q <= CAL_IDLE;
                    end
                end
                default: begin
                    calState_q <= CAL_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        statusD              = STATUS_RESET;
        statusD[ST_HOLD]     = cmdByte[CMD_HOLD];
        statusD[ST_STEADY]   = steady;
        statusD[ST_CAL]      = calState_q != CAL_IDLE;
        statusD[ST_TARE]     = tareChanged_q;
        statusD[ST_ADJ_ERR]  = adjError_q;
        statusD[ST_ADJ]      = adjChanged_q;
        statusD[ST_RSVD]     = 1'b0;
        statusD[ST_ZERO_REF] = zeroRef_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            statusByte <= STATUS_RESET;
        end else begin
            statusByte <= statusD;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_tare_low2;
        !tareHeld [*2];
    endsequence

    sequence s_adj_issue;
        !adjBusy_q && cmdRise[CMD_ADJ_STORE] && !cmdRise[CMD_ADJ_DELETE] ##1 adjStoreReq;
    endsequence

    a_hold_follow: assert property (
        ##1 statusByte[ST_HOLD] == $past(cmdByte[CMD_HOLD]))
        else $error("hold status does not follow hold command");

    a_hold_gate: assert property (
        cmdByte[CMD_HOLD] |=> !filterValid)
        else $error("sample passed to filter while hold active");

    a_rsvd_zero: assert property (
        statusByte[ST_RSVD] == 1'b0)
        else $error("reserved status bit not zero");

    a_tare_capture: assert property (
        cmdRise[CMD_TARE_SET] && !cmdRise[CMD_TARE_CLEAR]
        |=> tareValue == $past(lastSample_q) ##1 statusByte[ST_TARE])
        else $error("tare not captured or not acknowledged");

    a_tare_clear: assert property (
        cmdRise[CMD_TARE_CLEAR] |=> tareValue == TARE_CLEARED)
        else $error("tare not cleared to zero");

    a_tare_release: assert property (
        s_tare_low2 |=> !statusByte[ST_TARE])
        else $error("tare flag stays after command released");

    a_adj_once: assert property (
        s_adj_issue |=> !adjStoreReq)
        else $error("store request repeated");

    a_adj_error: assert property (
        adjBusy_q && adjFail |-> ##2 statusByte[ST_ADJ_ERR] && statusByte[ST_ADJ])
        else $error("adjustment failure not reported");

    a_zero_ack: assert property (
        cmdRise[CMD_REF_SET] |=> refPointPulse ##1 statusByte[ST_ZERO_REF])
        else $error("reference point not executed or acknowledged");

    a_cal_flag: assert property (
        calState_q != CAL_IDLE |=> statusByte[ST_CAL])
        else $error("calibration flag low while calibrating");

    a_steady_map: assert property (
        ##1 statusByte[ST_STEADY] == $past(steady))
        else $error("steady status not from internal detector");

endmodule : weigh_cmd_status

`default_nettype wire

// >>> core/weigh_pkg.sv
package weigh_pkg;

    localparam int CMD_W   = 8;
    localparam int DATA_W  = 32;
    localparam int DWELL_W = 16;

    // Process image offsets of the two bytes.
    localparam int CMD_OFFSET    = 0;
    localparam int STATUS_OFFSET = 3;

    // Command byte bit positions.
    localparam int CMD_HOLD       = 0;
    localparam int CMD_ADJ_STORE  = 1;
    localparam int CMD_ADJ_DELETE = 2;
    localparam int CMD_TARE_SET   = 3;
    localparam int CMD_TARE_CLEAR = 4;
    localparam int CMD_RSVD       = 5;
    localparam int CMD_ZERO_SET   = 6;
    localparam int CMD_REF_SET    = 7;

    // Status byte bit positions.
    localparam int ST_HOLD     = 0;
    localparam int ST_STEADY   = 1;
    localparam int ST_CAL      = 2;
    localparam int ST_TARE     = 3;
    localparam int ST_ADJ_ERR  = 4;
    localparam int ST_ADJ      = 5;
    localparam int ST_RSVD     = 6;
    localparam int ST_ZERO_REF = 7;

    localparam logic [7:0]  STATUS_RESET = 8'h00;
    localparam logic [31:0] DATA_RESET   = 32'h0000_0000;
    localparam logic [31:0] TARE_CLEARED = 32'h0000_0000;

    // Time base for dwell and calibration interval counts.
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_TIME_NS  = 1000000;
    localparam int TICK_CYCLES   = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        CAL_IDLE      = 3'b000,
        CAL_REQ_LOW   = 3'b001,
        CAL_WAIT_LOW  = 3'b010,
        CAL_REQ_HIGH  = 3'b011,
        CAL_WAIT_HIGH = 3'b100
    } cal_state_t;

endpackage : weigh_pkg

// >>> core/steady_watch.sv
`timescale 1ns/10ps
`default_nettype none

module steady_watch (
    input  wire logic                                  clk,
    input  wire logic                                  rst,
    input  wire logic                                  tick,
    input  wire logic                                  sampleValid,
    input  wire logic signed [weigh_pkg::DATA_W-1:0]   sampleData,
    input  wire logic        [weigh_pkg::DWELL_W-1:0]  dwellTime,
    input  wire logic        [weigh_pkg::DATA_W-1:0]   toleranceBand,
    output logic                                       steady
);
    import weigh_pkg::*;

    logic signed [DATA_W-1:0]  ref_q;
    logic        [DWELL_W-1:0] timer_q;
    logic signed [DATA_W:0]    diff;
    logic        [DATA_W:0]    mag;
    logic                      outside;

    always_comb begin
        diff    = {sampleData[DATA_W-1], sampleData} - {ref_q[DATA_W-1], ref_q};
        mag     = diff[DATA_W] ? 33'(-diff) : 33'(diff);
        outside = mag > {1'b0, toleranceBand};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ref_q   <= DATA_RESET;
            timer_q <= '0;
        end else if (sampleValid && outside) begin
            ref_q   <= sampleData;
            timer_q <= '0;
        end else if (tick && timer_q != '1) begin
            timer_q <= timer_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            steady <= 1'b0;
        end else if (sampleValid && outside) begin
            steady <= 1'b0;
        end else begin
            steady <= timer_q > dwellTime;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_steady_drop: assert property (
        sampleValid && outside |=> !steady ##0 timer_q == '0)
        else $error("steady flag kept after leaving tolerance");

    a_steady_dwell: assert property (
        $rose(steady) |-> $past(timer_q) > $past(dwellTime))
        else $error("steady flag rose before dwell time");

endmodule : steady_watch

`default_nettype wire

// >>> bench/weigh_far_model.sv
`timescale 1ns/10ps
`default_nettype none

module weigh_far_model #(
    parameter int                 Delay   = 5,
    parameter logic signed [31:0] RefLow  = 32'sh0000_0064,
    parameter logic signed [31:0] RefHigh = 32'sh0000_044c
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               calMeasReq,
    input  wire logic               calRefSel,
    output logic                    calRefValid,
    output logic signed [31:0]      calRefData,
    input  wire logic               adjStoreReq,
    input  wire logic               adjDeleteReq,
    input  wire logic               failNext,
    output logic                    adjDone,
    output logic                    adjFail
);
    int   calCnt;
    int   adjCnt;
    logic failQ;

    // answer each request with one of two references.
    always_ff @(posedge clk) begin
        if (rst) begin
            calCnt <= 0;
            calRefValid <= 1'b0;
            calRefData <= 32'sh0000_0000;
        end else begin
            calRefValid <= 1'b0;
            // Outside a result the data toggles so a stale value never matches.
            calRefData <= ~calRefData;
            if (calMeasReq) begin
                calCnt <= Delay;
            end else if (calCnt != 0) begin
                calCnt <= calCnt - 1;
                if (calCnt == 1) begin
                    calRefValid <= 1'b1;
                    calRefData <= calRefSel ? RefHigh : RefLow;
                end
            end
        end
    end

    // store or delete finishes late, failing on demand.
    always_ff @(posedge clk) begin
        if (rst) begin
            adjCnt <= 0;
            failQ <= 1'b0;
            adjDone <= 1'b0;
            adjFail <= 1'b0;
        end else begin
            adjDone <= 1'b0;
            adjFail <= 1'b0;
            if (adjStoreReq || adjDeleteReq) begin
                adjCnt <= Delay;
                failQ <= failNext;
            end else if (adjCnt != 0) begin
                adjCnt <= adjCnt - 1;
                if (adjCnt == 1) begin
                    adjDone <= ~failQ;
                    adjFail <= failQ;
                end
            end
        end
    end
endmodule : weigh_far_model

`default_nettype wire

// >>> bench/weigh_cmd_status_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module weigh_cmd_status_tb_top;
    import weigh_pkg::*;
    localparam int                 TICKS  = 4;
    localparam logic signed [31:0] SAMPLE = 32'sh0000_1234;
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] st;
        logic       fail;
    } row_t;

    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic [7:0]         cmdByte = 8'h00;
    logic [7:0]         statusByte;
    logic               sampleValid = 1'b0;
    logic signed [31:0] sampleData = 32'sh0000_0000;
    logic signed [31:0] curSample = SAMPLE;
    logic               filterValid;
    logic signed [31:0] filterData;
    logic [15:0]        steadyDwellTime = 16'h0003;
    logic [31:0]        steadyToleranceBand = 32'h0000_000a;
    logic [31:0]        calibrationInterval = 32'h0000_0000;
    logic               calMeasReq, calRefSel, calRefValid;
    logic signed [31:0] calRefData, calOffset, calGain, tareValue;
    logic               adjStoreReq, adjDeleteReq, adjDone, adjFail;
    logic               zeroPointPulse, refPointPulse;
    logic               failNext = 1'b0;
    logic [2:0]         div = 3'h0;
    int                 nMismatch = 0;
    int                 checksDone = 0;
    int                 fvCnt = 0, nZero = 0, nRef = 0, nStore = 0, nDel = 0;
    int                 n;
    row_t               rows[11] = '{
        '{8'h01, 8'h01, 1'b0}, '{8'h08, 8'h08, 1'b0}, '{8'h18, 8'h08, 1'b0},
        '{8'h08, 8'h08, 1'b0}, '{8'h10, 8'h08, 1'b0}, '{8'h02, 8'h20, 1'b0},
        '{8'h04, 8'h20, 1'b0}, '{8'h02, 8'h30, 1'b1}, '{8'h40, 8'h80, 1'b0},
        '{8'h80, 8'h80, 1'b0}, '{8'h20, 8'h00, 1'b0}};

    weigh_cmd_status #(.TickCycles(TICKS)) weigh_cmd_status_inst (
        .clk(clk), .rst(rst), .cmdByte(cmdByte), .statusByte(statusByte),
        .sampleValid(sampleValid), .sampleData(sampleData),
        .filterValid(filterValid), .filterData(filterData),
        .steadyDwellTime(steadyDwellTime), .steadyToleranceBand(steadyToleranceBand),
        .calibrationInterval(calibrationInterval), .calMeasReq(calMeasReq),
        .calRefSel(calRefSel), .calRefValid(calRefValid), .calRefData(calRefData),
        .calOffset(calOffset), .calGain(calGain), .tareValue(tareValue),
        .adjStoreReq(adjStoreReq), .adjDeleteReq(adjDeleteReq), .adjDone(adjDone),
        .adjFail(adjFail), .zeroPointPulse(zeroPointPulse), .refPointPulse(refPointPulse));

    weigh_far_model weigh_far_model_inst (
        .clk(clk), .rst(rst), .calMeasReq(calMeasReq), .calRefSel(calRefSel),
        .calRefValid(calRefValid), .calRefData(calRefData), .adjStoreReq(adjStoreReq),
        .adjDeleteReq(adjDeleteReq), .failNext(failNext), .adjDone(adjDone),
        .adjFail(adjFail));

    always #5 clk = ~clk;

    // A new measured value arrives every eighth cycle.
    always @(posedge clk) begin
        div <= div + 3'h1;
        sampleValid <= (div == 3'h7);
        sampleData <= curSample;
        fvCnt <= fvCnt + (filterValid === 1'b1);
        nZero <= nZero + (zeroPointPulse === 1'b1);
        nRef <= nRef + (refPointPulse === 1'b1);
        nStore <= nStore + (adjStoreReq === 1'b1);
        nDel <= nDel + (adjDeleteReq === 1'b1);
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checksDone++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            nMismatch++;
        end
    endtask : chk

    task automatic tick(input int cycles);
        repeat (cycles) @(posedge clk);
        #1;
    endtask : tick

    task automatic waitFor(input logic [7:0] mask, input logic [7:0] exp);
        int k;
        for (k = 0; k < 500 && (statusByte & mask) !== exp; k++) tick(1);
        if ((statusByte & mask) !== exp) begin
            $display("CHECK FAILED status wait expected %h seen %h", exp, statusByte & mask);
            nMismatch++;
            printVerdict();
        end
    endtask : waitFor

    task automatic printVerdict();
        $display("mismatches %0d checks %0d", nMismatch, checksDone);
        if (nMismatch == 0 && checksDone > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : printVerdict

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        chk("status after reset", STATUS_RESET, statusByte);
        for (int i = 0; i < 11; i++) begin
            @(posedge clk);
            failNext <= rows[i].fail;
            cmdByte <= rows[i].cmd;
            waitFor(8'hf9, rows[i].st);
            tick(3);
            chk("status ack", rows[i].st, statusByte & 8'hf9);
            if (rows[i].cmd[CMD_HOLD]) begin
                n = fvCnt;
                tick(20);
                chk("samples while held", n, fvCnt);
            end
            if (rows[i].cmd[4:3] != 2'b00) begin
                chk("tare value", rows[i].cmd[4] ? TARE_CLEARED : SAMPLE, tareValue);
            end
            @(posedge clk);
            cmdByte <= 8'h00;
            failNext <= 1'b0;
            tick(4);
            chk("status release", 8'h00, statusByte & 8'hf9);
        end
        chk("zero pulses", 1, nZero);
        chk("ref pulses", 1, nRef);
        chk("store pulses", 2, nStore);
        chk("delete pulses", 1, nDel);
        n = fvCnt;
        tick(20);
        chk("samples resume", 1, fvCnt > n);
        chk("filter data", SAMPLE, filterData);
        waitFor(8'h02, 8'h02);
        @(posedge clk);
        curSample <= SAMPLE + 32'sh0000_03e8;
        tick(10);
        chk("steady dropped", 0, statusByte[ST_STEADY]);
        waitFor(8'h02, 8'h02);
        @(posedge clk);
        calibrationInterval <= 32'h0000_0005;
        waitFor(8'h04, 8'h04);
        @(posedge clk);
        calibrationInterval <= 32'h0000_0000;
        waitFor(8'h04, 8'h00);
        chk("cal offset", 32'sh0000_0064, calOffset);
        chk("cal gain", 32'sh0000_03e8, calGain);
        @(posedge clk);
        cmdByte <= 8'h09;
        tick(4);
        chk("hold polled", 8'h09, statusByte & 8'hf9);
        chk("tare mid run", SAMPLE + 32'sh0000_03e8, tareValue);
        @(posedge clk);
        rst <= 1'b1;
        cmdByte <= 8'h00;
        tick(2);
        chk("status mid reset", STATUS_RESET, statusByte);
        chk("tare mid reset", DATA_RESET, tareValue);
        @(posedge clk);
        rst <= 1'b0;
        tick(2);
        chk("status after release", STATUS_RESET, statusByte);
        @(posedge clk);
        cmdByte <= 8'h01;
        tick(2);
        chk("hold after release", 8'h01, statusByte & 8'hf9);
        printVerdict();
    end
endmodule : weigh_cmd_status_tb_top

`default_nettype wire
